// ### ufe_defines.vh
`ifndef UFE_DEFINES_VH
`define UFE_DEFINES_VH
// Register indices (byte address is four times the index).
`define UFE_IDX_DATA      3'h0
`define UFE_IDX_IEN       3'h1
`define UFE_IDX_FIFO      3'h2
`define UFE_IDX_LINE      3'h3
`define UFE_IDX_MODEM     3'h4
`define UFE_IDX_LSTAT     3'h5
`define UFE_IDX_MSTAT     3'h6
`define UFE_IDX_SHADOW    3'h7
// Line control fields.
`define UFE_LC_DIV_ACCESS 7
`define UFE_LC_BREAK      6
`define UFE_LC_STICK      5
`define UFE_LC_EVEN       4
`define UFE_LC_PAR_EN     3
`define UFE_LC_STOP2      2
// Modem control fields.
`define UFE_MC_GATE       3
`define UFE_MC_LOOP       4
// Reset values.
`define UFE_DIV_RESET     16'h0001
`define UFE_LINE_RESET    8'h03
// Interrupt identification codes in bits 3:0.
`define UFE_ID_NONE       4'h1
`define UFE_ID_LINE       4'h6
`define UFE_ID_RDATA      4'h4
`define UFE_ID_TOUT       4'hc
`define UFE_ID_THRE       4'h2
`define UFE_ID_MODEM      4'h0
// Oversampling and timeout.
`define UFE_OVERSAMPLE    4'hf
`define UFE_TOUT_CHARS    4
`endif

// ### ufe_uart.v
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "ufe_defines.vh"
module ufe_uart #(
	parameter DEPTH = 16, // FIFO depth, power of two.
	parameter AW    = 4   // FIFO index width.
) (
	input  wire        CLK,       // System clock.
	input  wire        RST_N,     // Synchronous reset, active low.
	input  wire        HSEL,      // Slave select.
	input  wire [31:0] HADDR,     // Byte address.
	input  wire [1:0]  HTRANS,    // Transfer type.
	input  wire        HWRITE,    // Write when high.
	input  wire [2:0]  HSIZE,     // Transfer size.
	input  wire        HREADY,    // Bus ready in.
	input  wire [31:0] HWDATA,    // Write data.
	output reg  [31:0] HRDATA,    // Read data.
	output wire        HREADYOUT, // Slave ready, always high.
	output wire        HRESP,     // Always OKAY.
	input  wire        RXD,       // Serial input.
	output reg         TXD,       // Serial output.
	input  wire [3:0]  MODEM_IN,  // Modem status inputs, active high.
	output wire [3:0]  MODEM_OUT, // Modem control outputs.
	output wire        IRQ        // Interrupt, active high.
);
	reg  [7:0]    ien_reg, line_reg, modem_reg, fifo_ctl_reg;
	reg  [15:0]   div_reg;
	reg           fifo_en_reg;
	reg  [3:0]    ident_reg;
	reg           wr_ph_reg, rd_ph_reg;
	reg  [2:0]    idx_reg;
	reg  [7:0]    rx_mem [0:DEPTH-1];
	reg  [7:0]    tx_mem [0:DEPTH-1];
	reg  [AW:0]   rx_cnt_reg, tx_cnt_reg;
	reg  [AW-1:0] rx_rd_reg, tx_rd_reg;
	reg  [15:0]   baud_cnt_reg;
	reg  [1:0]    rxd_sync_reg;
	reg  [3:0]    mdm_s1_reg, mdm_s2_reg, mdm_prev_reg;
	reg  [3:0]    delta_reg;
	reg           overrun_reg, perr_reg, ferr_reg, brk_reg;
	reg           thre_int_reg;
	reg  [9:0]    tout_cnt_reg;
	reg           tout_reg;
	// Receiver.
	reg  [1:0]    rx_st_reg;
	reg  [3:0]    rx_tick_reg;
	reg  [3:0]    rx_bit_reg;
	reg  [7:0]    rx_sh_reg;
	reg           rx_par_reg;
	reg           rx_pbit_reg;
	// Transmitter.
	reg  [1:0]    tx_st_reg;
	reg  [3:0]    tx_tick_reg;
	reg  [3:0]    tx_bit_reg;
	reg  [7:0]    tx_sh_reg;
	reg           tx_par_reg;

	localparam [1:0] ST_IDLE  = 2'h1;
	localparam [1:0] ST_SHIFT = 2'h2;

	wire       bus_go  = HSEL & HTRANS[1] & HREADY;
	wire       wr_en   = wr_ph_reg;
	wire [7:0] wdat    = HWDATA[7:0];
	wire       divisor_access_bit    = line_reg[`UFE_LC_DIV_ACCESS];
	wire       loop    = modem_reg[`UFE_MC_LOOP];
	wire       rd_data = rd_ph_reg & (idx_reg == `UFE_IDX_DATA) & ~divisor_access_bit;
	wire       rd_id   = rd_ph_reg & (idx_reg == `UFE_IDX_FIFO);
	wire       rd_ls   = rd_ph_reg & (idx_reg == `UFE_IDX_LSTAT);
	wire       rd_ms   = rd_ph_reg & (idx_reg == `UFE_IDX_MSTAT);
	wire       wr_data = wr_en & (idx_reg == `UFE_IDX_DATA) & ~divisor_access_bit;
	wire       wr_fifo = wr_en & (idx_reg == `UFE_IDX_FIFO);
	wire [4:0] cap     = fifo_en_reg ? DEPTH[4:0] : 5'h01;
	wire       rx_empty = (rx_cnt_reg == 0);
	wire       tx_empty = (tx_cnt_reg == 0);
	wire       rx_push;
	wire [7:0] rx_word;
	wire       tick    = (baud_cnt_reg == 16'h0001) | (div_reg <= 16'h0001);
	wire       tx_pop  = (tx_st_reg == ST_IDLE) & ~tx_empty & tick;
	wire       rx_pop  = rd_data & ~rx_empty;
	wire       rx_in   = loop ? TXD : rxd_sync_reg[1];
	wire [3:0] mdm_now = loop ? modem_reg[3:0] : mdm_s2_reg;
	wire [4:0] trig;

	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign MODEM_OUT = loop ? 4'h0 : modem_reg[3:0];

	// Receive trigger level decode.
	assign trig = (fifo_ctl_reg[7:6] == 2'h0) ? 5'd1 :
	              (fifo_ctl_reg[7:6] == 2'h1) ? 5'd4 :
	              (fifo_ctl_reg[7:6] == 2'h2) ? 5'd8 : 5'd14;

	// Sources, each gated by its enable bit.
	wire src_line  = ien_reg[2] & (overrun_reg | perr_reg | ferr_reg | brk_reg);
	wire src_tout  = ien_reg[0] & fifo_en_reg & tout_reg;
	wire src_rdata = ien_reg[0] & (fifo_en_reg ? (rx_cnt_reg >= trig) : ~rx_empty);
	wire src_thre  = ien_reg[1] & thre_int_reg;
	wire src_modem = ien_reg[3] & (|delta_reg);
	reg  [3:0] ident_next;

	// Priority encoder for the pending source.
	always @* begin
		if (src_line)
			ident_next = `UFE_ID_LINE;
		else if (src_rdata)
			ident_next = `UFE_ID_RDATA;
		else if (src_tout)
			ident_next = `UFE_ID_TOUT;
		else if (src_thre)
			ident_next = `UFE_ID_THRE;
		else if (src_modem)
			ident_next = `UFE_ID_MODEM;
		else
			ident_next = `UFE_ID_NONE;
	end

	// Interrupt reaches the pin only through the gate bit.
	assign IRQ = modem_reg[`UFE_MC_GATE] & ~ident_reg[0];

	// Bus address phase capture; the data phase follows.
	always @(posedge CLK) begin
		if (!RST_N) begin
			wr_ph_reg <= 1'b0;
			rd_ph_reg <= 1'b0;
			idx_reg   <= 3'h0;
		end else begin
			wr_ph_reg <= bus_go & HWRITE;
			rd_ph_reg <= bus_go & ~HWRITE;
			if (bus_go)
				idx_reg <= HADDR[4:2];
		end
	end

	// Identification value is held while a read of it is in progress.
	always @(posedge CLK) begin
		if (!RST_N)
			ident_reg <= `UFE_ID_NONE;
		else if (!(rd_id || (bus_go && !HWRITE && HADDR[4:2] == `UFE_IDX_FIFO)))
			ident_reg <= ident_next;
	end

	// Head of the receive FIFO, one further on if a data read is popping it now.
	wire [AW-1:0] rx_head = rx_rd_reg + {{(AW-1){1'b0}}, rx_pop};

	// Read data mux, registered at the address phase.
	always @(posedge CLK) begin
		if (!RST_N) begin
			HRDATA <= 32'h0;
		end else if (bus_go && !HWRITE) begin
			HRDATA <= 32'h0;
			case (HADDR[4:2])
				`UFE_IDX_DATA:   HRDATA[7:0] <= divisor_access_bit ? div_reg[7:0] : rx_mem[rx_head];
				`UFE_IDX_IEN:    HRDATA[7:0] <= divisor_access_bit ? div_reg[15:8] : {4'h0, ien_reg[3:0]};
				`UFE_IDX_FIFO:   HRDATA[7:0] <= {{2{fifo_en_reg}}, 2'h0, ident_reg};
				`UFE_IDX_LINE:   HRDATA[7:0] <= line_reg;
				`UFE_IDX_MODEM:  HRDATA[7:0] <= modem_reg;
				`UFE_IDX_LSTAT:  HRDATA[7:0] <= {1'b0, tx_empty & (tx_st_reg == ST_IDLE),
				                  tx_empty, brk_reg, ferr_reg, perr_reg, overrun_reg, ~rx_empty};
				`UFE_IDX_MSTAT:  HRDATA[7:0] <= {mdm_now, delta_reg};
				`UFE_IDX_SHADOW: HRDATA[7:0] <= fifo_ctl_reg;
				default:         HRDATA[7:0] <= 8'h0;
			endcase
		end
	end

	// Control register writes.
	always @(posedge CLK) begin
		if (!RST_N) begin
			ien_reg      <= 8'h0;
			line_reg     <= `UFE_LINE_RESET;
			modem_reg    <= 8'h0;
			div_reg      <= `UFE_DIV_RESET;
			fifo_ctl_reg <= 8'h0;
			fifo_en_reg  <= 1'b0;
		end else if (wr_en) begin
			case (idx_reg)
				`UFE_IDX_DATA:  if (divisor_access_bit) div_reg[7:0] <= wdat;
				`UFE_IDX_IEN:   if (divisor_access_bit) div_reg[15:8] <= wdat; else ien_reg <= {4'h0, wdat[3:0]};
				`UFE_IDX_FIFO:  begin
					fifo_en_reg  <= wdat[0];
					fifo_ctl_reg <= wdat[0] ? wdat : 8'h0;
				end
				`UFE_IDX_LINE:  line_reg <= wdat;
				`UFE_IDX_MODEM: modem_reg <= {3'h0, wdat[4:0]};
				default:        ;
			endcase
		end
	end

	// Baud divider: one enable pulse per divisor count at sixteen times the rate.
	always @(posedge CLK) begin
		if (!RST_N)
			baud_cnt_reg <= `UFE_DIV_RESET;
		else if (tick)
			baud_cnt_reg <= div_reg;
		else
			baud_cnt_reg <= baud_cnt_reg - 16'h0001;
	end

	// Pin synchronisers.
	always @(posedge CLK) begin
		if (!RST_N) begin
			rxd_sync_reg <= 2'h3;
			mdm_s1_reg   <= 4'h0;
			mdm_s2_reg   <= 4'h0;
		end else begin
			rxd_sync_reg <= {rxd_sync_reg[0], RXD};
			mdm_s1_reg   <= MODEM_IN;
			mdm_s2_reg   <= mdm_s1_reg;
		end
	end

	// Modem change deltas; a new change wins over the clearing read.
	always @(posedge CLK) begin
		if (!RST_N) begin
			mdm_prev_reg <= 4'h0;
			delta_reg    <= 4'h0;
		end else begin
			mdm_prev_reg <= mdm_now;
			delta_reg    <= (rd_ms ? 4'h0 : delta_reg) | (mdm_now ^ mdm_prev_reg);
		end
	end

	// Receiver: start, data LSB first, parity, first stop only.
	wire [3:0] rx_bits = 4'd5 + {2'h0, line_reg[1:0]};
	// Stick parity expects the inverse of the even bit; otherwise data and parity sum checked.
	wire       par_err = line_reg[`UFE_LC_STICK] ? (rx_pbit_reg == line_reg[`UFE_LC_EVEN]) :
	                     ((rx_par_reg ^ rx_pbit_reg) == line_reg[`UFE_LC_EVEN]);
	wire [3:0] rx_last = rx_bits + {3'h0, line_reg[`UFE_LC_PAR_EN]};
	assign rx_push = tick & (rx_st_reg == ST_SHIFT) & (rx_tick_reg == `UFE_OVERSAMPLE)
	                 & (rx_bit_reg == rx_last + 4'd1);
	assign rx_word = rx_sh_reg >> (4'd8 - rx_bits);
	wire       stop_bad = rx_push & ~rx_in;
	wire       rx_full  = (rx_cnt_reg >= {1'b0, cap[AW-1:0]}) & ~fifo_en_reg |
	                      (rx_cnt_reg == DEPTH[AW:0]);
	always @(posedge CLK) begin
		if (!RST_N) begin
			rx_st_reg   <= ST_IDLE;
			rx_tick_reg <= 4'h0;
			rx_bit_reg  <= 4'h0;
			rx_sh_reg   <= 8'h0;
			rx_par_reg  <= 1'b0;
			rx_pbit_reg <= 1'b0;
		end else if (tick) begin
			case (rx_st_reg)
				ST_IDLE: begin
					rx_tick_reg <= 4'h8;
					rx_bit_reg  <= 4'h0;
					rx_par_reg  <= 1'b0;
					if (!rx_in)
						rx_st_reg <= ST_SHIFT;
				end
				ST_SHIFT: begin
					rx_tick_reg <= rx_tick_reg + 4'h1;
					if (rx_tick_reg == `UFE_OVERSAMPLE) begin
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == 4'h0 && rx_in)
							rx_st_reg <= ST_IDLE;
						else if (rx_bit_reg != 4'h0 && rx_bit_reg <= rx_bits) begin
							rx_sh_reg  <= {rx_in, rx_sh_reg[7:1]};
							rx_par_reg <= rx_par_reg ^ rx_in;
						end else if (rx_bit_reg == rx_last)
							rx_pbit_reg <= rx_in;
						else if (rx_bit_reg == rx_last + 4'd1)
							rx_st_reg <= ST_IDLE;
					end
				end
				default: rx_st_reg <= ST_IDLE;
			endcase
		end
	end

	// Receive FIFO; bit one or leaving FIFO mode empties it, shifter untouched.
	wire rx_clr = wr_fifo & (~wdat[0] | wdat[1]);
	wire rx_wr  = rx_push & ~rx_full;
	always @(posedge CLK) begin
		if (!RST_N) begin
			rx_cnt_reg <= {(AW+1){1'b0}};
			rx_rd_reg  <= {AW{1'b0}};
		end else if (rx_clr) begin
			rx_cnt_reg <= {(AW+1){1'b0}};
			rx_rd_reg  <= {AW{1'b0}};
		end else begin
			if (rx_wr)
				rx_mem[rx_rd_reg + rx_cnt_reg[AW-1:0]] <= rx_word;
			if (rx_pop)
				rx_rd_reg <= rx_rd_reg + {{(AW-1){1'b0}}, 1'b1};
			rx_cnt_reg <= rx_cnt_reg + {{AW{1'b0}}, rx_wr} - {{AW{1'b0}}, rx_pop};
		end
	end

	// Line status flags; detection wins over the clearing read.
	always @(posedge CLK) begin
		if (!RST_N) begin
			overrun_reg <= 1'b0;
			perr_reg    <= 1'b0;
			ferr_reg    <= 1'b0;
			brk_reg     <= 1'b0;
		end else begin
			overrun_reg <= (overrun_reg & ~rd_ls) | (rx_push & rx_full);
			perr_reg    <= (perr_reg & ~rd_ls) | (rx_push & line_reg[`UFE_LC_PAR_EN] & par_err);
			ferr_reg    <= (ferr_reg & ~rd_ls) | stop_bad;
			brk_reg     <= (brk_reg & ~rd_ls) | (stop_bad & (rx_word == 8'h0));
		end
	end

	// Character timeout: four character times of no FIFO activity.
	wire [9:0] char_ticks = {2'h0, rx_last + 4'd2, 4'h0};
	always @(posedge CLK) begin
		if (!RST_N) begin
			tout_cnt_reg <= 10'h0;
			tout_reg     <= 1'b0;
		end else if (rx_empty || rx_wr || rx_pop || !fifo_en_reg) begin
			tout_cnt_reg <= 10'h0;
			tout_reg     <= 1'b0;
		end else if (tick && !tout_reg) begin
			tout_cnt_reg <= tout_cnt_reg + 10'h1;
			if (tout_cnt_reg == char_ticks * `UFE_TOUT_CHARS)
				tout_reg <= 1'b1;
		end
	end

	// Transmit FIFO; bit two or leaving FIFO mode empties it.
	wire tx_clr  = wr_fifo & (~wdat[0] | wdat[2]);
	wire tx_full = tx_cnt_reg >= cap;
	wire tx_wr   = wr_data & ~tx_full;
	always @(posedge CLK) begin
		if (!RST_N) begin
			tx_cnt_reg <= {(AW+1){1'b0}};
			tx_rd_reg  <= {AW{1'b0}};
		end else if (tx_clr) begin
			tx_cnt_reg <= {(AW+1){1'b0}};
			tx_rd_reg  <= {AW{1'b0}};
		end else begin
			if (tx_wr)
				tx_mem[tx_rd_reg + tx_cnt_reg[AW-1:0]] <= wdat;
			if (tx_pop)
				tx_rd_reg <= tx_rd_reg + {{(AW-1){1'b0}}, 1'b1};
			tx_cnt_reg <= tx_cnt_reg + {{AW{1'b0}}, tx_wr} - {{AW{1'b0}}, tx_pop};
		end
	end

	// Holding-empty event; set wins over the clearing read or write.
	always @(posedge CLK) begin
		if (!RST_N)
			thre_int_reg <= 1'b0;
		else if (tx_pop && tx_cnt_reg == 1)
			thre_int_reg <= 1'b1;
		else if (wr_data || (rd_id && ident_reg == `UFE_ID_THRE))
			thre_int_reg <= 1'b0;
		else if (wr_en && idx_reg == `UFE_IDX_IEN && !divisor_access_bit && wdat[1] && !ien_reg[1] && tx_empty)
			thre_int_reg <= 1'b1;
	end

	// Transmitter loads only when the previous character is done.
	wire [3:0] tx_bits  = 4'd5 + {2'h0, line_reg[1:0]};
	wire [3:0] tx_last  = tx_bits + {3'h0, line_reg[`UFE_LC_PAR_EN]};
	wire       half_ext = line_reg[`UFE_LC_STOP2] & (line_reg[1:0] == 2'h0);
	wire [3:0] tx_end   = tx_last + 4'd1 + {3'h0, line_reg[`UFE_LC_STOP2]}; // Half bit cut below.
	wire       tx_pbit  = line_reg[`UFE_LC_STICK] ? ~line_reg[`UFE_LC_EVEN] :
	                      (tx_par_reg ^ ~line_reg[`UFE_LC_EVEN]);
	always @(posedge CLK) begin
		if (!RST_N) begin
			tx_st_reg   <= ST_IDLE;
			tx_tick_reg <= 4'h0;
			tx_bit_reg  <= 4'h0;
			tx_sh_reg   <= 8'h0;
			tx_par_reg  <= 1'b0;
			TXD         <= 1'b1;
		end else if (tick) begin
			case (tx_st_reg)
				ST_IDLE: begin
					TXD <= ~line_reg[`UFE_LC_BREAK] | loop;
					if (tx_pop) begin
						tx_sh_reg   <= tx_mem[tx_rd_reg];
						tx_st_reg   <= ST_SHIFT;
						tx_tick_reg <= 4'h0;
						tx_bit_reg  <= 4'h0;
						tx_par_reg  <= 1'b0;
					end
				end
				ST_SHIFT: begin
					tx_tick_reg <= tx_tick_reg + 4'h1;
					if (tx_bit_reg == 4'h0)
						TXD <= 1'b0;
					else if (tx_bit_reg <= tx_bits)
						TXD <= tx_sh_reg[0];
					else if (tx_bit_reg == tx_last && line_reg[`UFE_LC_PAR_EN])
						TXD <= tx_pbit;
					else
						TXD <= 1'b1;
					if (line_reg[`UFE_LC_BREAK])
						TXD <= 1'b0;
					if (tx_tick_reg == `UFE_OVERSAMPLE) begin
						tx_bit_reg <= tx_bit_reg + 4'h1;
						if (tx_bit_reg != 4'h0 && tx_bit_reg <= tx_bits) begin
							tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
							tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
						end
						if (tx_bit_reg == tx_end)
							tx_st_reg <= ST_IDLE;
					end else if (half_ext && tx_bit_reg == tx_end && tx_tick_reg == 4'h7)
						tx_st_reg <= ST_IDLE;
				end
				default: tx_st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // ufe_uart

// ### ufe_uart_monitor.sv
`timescale 1ns/10ps
`include "ufe_defines.vh"
// Checks bus answers, identification codes and the interrupt gate.
module ufe_uart_monitor #(
	parameter DEPTH = 16 // FIFO depth of the watched block.
) (
	input wire logic        CLK,       // Clock.
	input wire logic        RST_N,     // Reset, active low.
	input wire logic        HSEL,      // Slave select.
	input wire logic [31:0] HADDR,     // Byte address.
	input wire logic [1:0]  HTRANS,    // Transfer type.
	input wire logic        HWRITE,    // Write when high.
	input wire logic [2:0]  HSIZE,     // Transfer size.
	input wire logic        HREADY,    // Bus ready in.
	input wire logic [31:0] HWDATA,    // Write data.
	input wire logic [31:0] HRDATA,    // Read data.
	input wire logic        HREADYOUT, // Slave ready.
	input wire logic        HRESP,     // Response.
	input wire logic        RXD,       // Serial input.
	input wire logic        TXD,       // Serial output.
	input wire logic [3:0]  MODEM_IN,  // Modem inputs.
	input wire logic [3:0]  MODEM_OUT, // Modem outputs.
	input wire logic        IRQ        // Interrupt.
);
	logic       ap_v_reg, ap_w_reg, divisor_access_bit_reg, gate_reg;
	logic [2:0] ap_a_reg;
	logic [7:0] div_lo_reg, shadow_reg, ien_reg;
	// Read data phases of the places under watch.
	wire rd_any = ap_v_reg && !ap_w_reg;
	wire rd_id  = rd_any && ap_a_reg == `UFE_IDX_FIFO;
	wire rd_ien = rd_any && ap_a_reg == `UFE_IDX_IEN && !divisor_access_bit_reg;
	wire rd_div = rd_any && ap_a_reg == `UFE_IDX_DATA && divisor_access_bit_reg;
	wire rd_sh  = rd_any && ap_a_reg == `UFE_IDX_SHADOW;
	// Mirrors the host's writes so that read answers can be predicted.
	always @(posedge CLK) begin
		if (!RST_N) begin
			ap_v_reg   <= 1'b0;
			divisor_access_bit_reg   <= 1'b0;
			gate_reg   <= 1'b0;
			div_lo_reg <= 8'(`UFE_DIV_RESET);
			shadow_reg <= 8'h00;
			ien_reg    <= 8'h00;
		end else begin
			ap_v_reg <= HSEL && HTRANS[1] && HREADY;
			ap_w_reg <= HWRITE;
			ap_a_reg <= HADDR[4:2];
			if (ap_v_reg && ap_w_reg) begin
				case (ap_a_reg)
					`UFE_IDX_LINE: divisor_access_bit_reg <= HWDATA[7];
					`UFE_IDX_MODEM: gate_reg <= HWDATA[3];
					`UFE_IDX_FIFO: shadow_reg <= HWDATA[0] ? HWDATA[7:0] : 8'h00;
					`UFE_IDX_DATA: if (divisor_access_bit_reg) div_lo_reg <= HWDATA[7:0];
					`UFE_IDX_IEN: if (!divisor_access_bit_reg) ien_reg <= HWDATA[7:0];
					default: ;
				endcase
			end
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	hready_high_a: assert property (HREADYOUT) else $error("slave not ready");
	resp_okay_a: assert property (!HRESP) else $error("error response");
	rdata_upper_a: assert property (rd_any |-> HRDATA[31:8] == 24'h0) else $error("upper data");
	txd_reset_a: assert property ($rose(RST_N) |-> TXD) else $error("line not idle");
	ien_upper_a: assert property (rd_ien |-> HRDATA[7:4] == 4'h0) else $error("enable upper");
	div_read_a: assert property (rd_div |-> HRDATA[7:0] == div_lo_reg) else $error("divisor");
	shadow_read_a: assert property (rd_sh |-> HRDATA[7:0] == shadow_reg)
		else $error("shadow value");
	ident_mode_a: assert property (rd_id |-> HRDATA[7:4] == {{2{shadow_reg[0]}}, 2'b00})
		else $error("ident mode bits");
	ident_tout_a: assert property (rd_id && HRDATA[3] |-> HRDATA[2]) else $error("timeout code");
	ident_none_a: assert property (rd_id && HRDATA[0] |-> HRDATA[3:1] == 3'h0) else $error("none");
	irq_ident_a: assert property (rd_id && $past(IRQ) |-> !HRDATA[0]) else $error("irq vs ident");
	irq_gate_a: assert property (!gate_reg |-> !IRQ) else $error("irq with gate off");
	ien_off_a: assert property (rd_id && ien_reg[3:0] == 4'h0 |-> HRDATA[3:0] == `UFE_ID_NONE)
		else $error("pending while disabled");
	cover property (rd_id && HRDATA[3:0] == `UFE_ID_TOUT);
	cover property (rd_id && HRDATA[3:0] == `UFE_ID_LINE);
	cover property ($rose(IRQ));
endmodule // ufe_uart_monitor

// ### ufe_term.sv
`timescale 1ns/10ps
// Terminal at the far end of the serial line, 8 data bits, no parity.
module ufe_term #(
	parameter int BIT_CLKS = 16 // Clock cycles per bit at divisor one.
) (
	input  wire logic clk,  // Bench clock.
	input  wire logic txd,  // Serial data from the block.
	output logic      line  // Serial data towards the block.
);
	logic [7:0] got_q[$]; // Characters heard from the block.
	logic [7:0] rx_v;     // Character being assembled.
	// Sends one frame LSB first, or a break held far past a frame.
	task automatic send(input logic [7:0] data, input logic brk);
		line <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			line <= data[i] & !brk;
			repeat (BIT_CLKS) @(posedge clk);
		end
		line <= !brk;
		repeat (BIT_CLKS * (brk ? 12 : 1)) @(posedge clk);
		line <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask
	// Samples each character from the block at mid-bit.
	initial begin
		line = 1'b1;
		forever begin
			@(negedge txd);
			repeat (BIT_CLKS / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge clk);
				rx_v[i] = txd;
			end
			repeat (BIT_CLKS) @(posedge clk);
			got_q.push_back(rx_v);
		end
	end
endmodule // ufe_term

// ### tb_ufe_uart.sv
`timescale 1ns/10ps
`include "ufe_defines.vh"
// Self-checking bench for the serial front end.
module tb_ufe_uart;
	localparam int LIMIT = 20000; // Cycle ceiling for the whole run.
	logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, rxd, txd, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  modem_in, modem_out;
	logic [7:0]  b [4];
	logic [7:0]  d, v;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	ufe_uart i_ufe_uart (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .RXD(rxd), .TXD(txd), .MODEM_IN(modem_in),
		.MODEM_OUT(modem_out), .IRQ(irq));
	ufe_term i_ufe_term (.clk(clk), .txd(txd), .line(rxd));
	// Clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			report_and_stop();
		end
	end
	// Expected identification value.
	function automatic logic [7:0] idv(input logic fifo, input logic [3:0] code);
		return {{2{fifo}}, 2'b00, code};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One single word transfer; read data is taken at the end of the data phase.
	task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {27'h0, idx, 2'b00};
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata[7:0];
	endtask
	task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
		logic [7:0] r;
		bus(1'b1, idx, wd, r);
	endtask
	task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		bus(1'b0, idx, 8'h00, r);
		chk(r, exp);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		modem_in = 4'h0;
		void'($urandom(32'hf612d5f3));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`UFE_IDX_IEN, 8'h00);
		rdc(`UFE_IDX_FIFO, idv(0, `UFE_ID_NONE));
		rdc(`UFE_IDX_LINE, `UFE_LINE_RESET);
		wr(`UFE_IDX_IEN, 8'hff);
		rdc(`UFE_IDX_IEN, 8'h0f);
		wr(`UFE_IDX_IEN, 8'h05);
		done("enable");
		d = 8'($urandom) | 8'h01;
		wr(`UFE_IDX_LINE, 8'h83);
		wr(`UFE_IDX_DATA, d);
		wr(`UFE_IDX_IEN, 8'h00);
		rdc(`UFE_IDX_DATA, d);
		rdc(`UFE_IDX_IEN, 8'h00);
		wr(`UFE_IDX_DATA, 8'h01);
		wr(`UFE_IDX_LINE, 8'h03);
		rdc(`UFE_IDX_IEN, 8'h05);
		done("divisor");
		wr(`UFE_IDX_FIFO, 8'hc1);
		rdc(`UFE_IDX_SHADOW, 8'hc1);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		wr(`UFE_IDX_FIFO, 8'h00);
		rdc(`UFE_IDX_FIFO, idv(0, `UFE_ID_NONE));
		rdc(`UFE_IDX_SHADOW, 8'h00);
		done("fifo");
		wr(`UFE_IDX_FIFO, 8'h07);
		wr(`UFE_IDX_MODEM, 8'h08);
		wr(`UFE_IDX_IEN, 8'h02);
		repeat (2) @(posedge clk);
		chk({7'h0, irq}, 8'h01);
		chk({4'h0, modem_out}, 8'h08);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_THRE));
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		for (int i = 0; i < 2; i++) begin
			b[i] = 8'($urandom);
			wr(`UFE_IDX_DATA, b[i]);
		end
		while (i_ufe_term.got_q.size() < 2) @(posedge clk);
		for (int i = 0; i < 2; i++) chk(i_ufe_term.got_q.pop_front(), b[i]);
		wr(`UFE_IDX_MODEM, 8'h00);
		repeat (2) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_THRE));
		done("transmit");
		wr(`UFE_IDX_IEN, 8'h01);
		wr(`UFE_IDX_FIFO, 8'h47);
		for (int i = 0; i < 4; i++) begin
			b[i] = 8'($urandom);
			i_ufe_term.send(b[i], 1'b0);
			if (i == 2) rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		end
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_RDATA));
		for (int i = 0; i < 4; i++) rdc(`UFE_IDX_DATA, b[i]);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		i_ufe_term.send(b[0], 1'b0);
		repeat (1000) @(posedge clk);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_TOUT));
		rdc(`UFE_IDX_DATA, b[0]);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		i_ufe_term.send(b[1], 1'b0);
		i_ufe_term.send(b[2], 1'b0);
		wr(`UFE_IDX_DATA, b[3]);
		wr(`UFE_IDX_DATA, b[3]);
		wr(`UFE_IDX_FIFO, 8'h47);
		rdc(`UFE_IDX_LSTAT, 8'h20);
		done("receive");
		wr(`UFE_IDX_IEN, 8'h05);
		d = 8'($urandom);
		wr(`UFE_IDX_LINE, 8'h1b);
		i_ufe_term.send(d, 1'b0);
		bus(1'b0, `UFE_IDX_LSTAT, 8'h00, v);
		chk({7'h0, v[2]}, {7'h0, ~^d});
		wr(`UFE_IDX_LINE, 8'h03);
		i_ufe_term.send(8'h00, 1'b1);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_LINE));
		bus(1'b0, `UFE_IDX_LSTAT, 8'h00, v);
		chk({7'h0, v[4]}, 8'h01);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		chk(8'(i_ufe_term.got_q.size()), 8'h01);
		wr(`UFE_IDX_FIFO, 8'h43);
		done("line");
		wr(`UFE_IDX_IEN, 8'h08);
		bus(1'b0, `UFE_IDX_MSTAT, 8'h00, v);
		modem_in <= 4'h1;
		repeat (4) @(posedge clk);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_MODEM));
		bus(1'b0, `UFE_IDX_MSTAT, 8'h00, v);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		modem_in <= 4'h0;
		wr(`UFE_IDX_MODEM, 8'h08);
		wr(`UFE_IDX_IEN, 8'h00);
		repeat (4) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		rdc(`UFE_IDX_FIFO, idv(1, `UFE_ID_NONE));
		done("modem");
		report_and_stop();
	end
endmodule // tb_ufe_uart

bind ufe_uart ufe_uart_monitor #(.DEPTH(DEPTH)) i_ufe_uart_monitor (.CLK(CLK), .RST_N(RST_N),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
	.HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.RXD(RXD), .TXD(TXD), .MODEM_IN(MODEM_IN), .MODEM_OUT(MODEM_OUT), .IRQ(IRQ));
